// file: design/ssrg_pkg.sv
// package of constants for the supply supervisor reset generator
// Overview of operation
// - supply below threshold drives reset active after the supply propagation delay
// - reset releases only after the full delay, started once both conditions clear
// - manual reset input is active low and forces reset regardless of supply
// - strap low selects 10 ms release delay, strap high selects 200 ms
// - active-low push-pull variant drives high when inactive, low when active
// - active-high push-pull variant drives low when inactive, high when active
// - open-drain variant pulls low when active and releases when inactive
// - reset active when supply low or manual reset low, else may release
package ssrg_pkg;
    // clock rate
    localparam int unsigned CLOCK_HZ = 100000000;
    // release delays in milliseconds
    localparam int unsigned DELAY_SHORT_MS = 10;
    localparam int unsigned DELAY_LONG_MS = 200;
    // propagation delays, in nanoseconds (typical figures)
    localparam int unsigned PROP_SUPPLY_NS = 10000;
    localparam int unsigned PROP_MANUAL_NS = 300;
    localparam int unsigned CLOCK_NS = 1000000000 / CLOCK_HZ;
    // derived cycle counts, rounded down, not clamped to one cycle
    localparam int unsigned PROP_SUPPLY_CYC = PROP_SUPPLY_NS / CLOCK_NS;
    localparam int unsigned PROP_MANUAL_CYC = PROP_MANUAL_NS / CLOCK_NS;
    localparam longint unsigned DELAY_SHORT_CYC = 64'(DELAY_SHORT_MS) * (CLOCK_HZ / 1000);
    localparam longint unsigned DELAY_LONG_CYC = 64'(DELAY_LONG_MS) * (CLOCK_HZ / 1000);
    // counter widths
    localparam int unsigned DELAY_W = 25;
    localparam int unsigned PROP_W = 11;
    // output variant codes
    localparam logic [1:0] VARIANT_PP_LOW = 2'h0;
    localparam logic [1:0] VARIANT_PP_HIGH = 2'h1;
    localparam logic [1:0] VARIANT_OD_LOW = 2'h2;
    // sequencer states
    typedef enum logic [1:0] {
        SSRG_HOLD,
        SSRG_COUNT,
        SSRG_RELEASED
    } ssrg_state_type;
endpackage : ssrg_pkg

// file: design/ssrg_assert_delay.sv
`timescale 1ns/100ps
// persistence filter: output rises once input has been stable high, falls at once
module ssrg_assert_delay #(
    parameter int unsigned CYCLES = 1
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // condition in and delayed condition out
    input wire logic cond_in,
    output logic cond_out
);
    logic [ssrg_pkg::PROP_W-1:0] cnt_reg;
    logic [ssrg_pkg::PROP_W-1:0] cnt_next;
    logic out_reg;
    logic out_next;

    // assert only once the condition held for CYCLES clocks, clear at once
    always_comb begin
        cnt_next = '0;
        out_next = 1'b0;
        if (cond_in) begin
            if (out_reg || cnt_reg == ssrg_pkg::PROP_W'(CYCLES - 1)) begin
                out_next = 1'b1;
                cnt_next = cnt_reg;
            end else begin
                cnt_next = cnt_reg + ssrg_pkg::PROP_W'(1);
            end
        end
    end

    // registers; a fault is assumed at reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            out_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_next;
            out_reg <= out_next;
        end
    end

    assign cond_out = out_reg;
endmodule : ssrg_assert_delay

// file: design/ssrg_top.sv
`timescale 1ns/100ps
// reset generator: combines supply monitor and manual reset, timed release
module ssrg_top #(
    parameter logic [1:0] VARIANT = ssrg_pkg::VARIANT_PP_LOW,
    parameter logic [24:0] DELAY_SHORT_CYC = 25'(ssrg_pkg::DELAY_SHORT_CYC),
    parameter logic [24:0] DELAY_LONG_CYC = 25'(ssrg_pkg::DELAY_LONG_CYC)
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // pin inputs, asynchronous
    input wire logic supply_low,
    input wire logic manual_reset_n,
    input wire logic delay_select_strap,
    // reset output pin and its enable
    output logic reset_out,
    output logic reset_out_oe,
    // internal status
    output logic reset_active
);
    // two-flop synchronisers for the pins
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sync1_reg <= 3'h3;
            sync2_reg <= 3'h3;
        end else begin
            sync1_reg <= {delay_select_strap, ~manual_reset_n, supply_low};
            sync2_reg <= sync1_reg;
        end
    end

    logic supply_fault;
    logic manual_fault;

    ssrg_assert_delay #(
        .CYCLES(ssrg_pkg::PROP_SUPPLY_CYC)
    ) u_supply_delay (
        .clock(clock),
        .rst(rst),
        .cond_in(sync2_reg[0]),
        .cond_out(supply_fault)
    );

    ssrg_assert_delay #(
        .CYCLES(ssrg_pkg::PROP_MANUAL_CYC)
    ) u_manual_delay (
        .clock(clock),
        .rst(rst),
        .cond_in(sync2_reg[1]),
        .cond_out(manual_fault)
    );

    logic fault;
    assign fault = supply_fault | manual_fault;

    // strap caught at every hold, so it may change with power
    logic [24:0] delay_target;
    assign delay_target = sync2_reg[2] ? DELAY_LONG_CYC : DELAY_SHORT_CYC;

    ssrg_pkg::ssrg_state_type state_reg;
    ssrg_pkg::ssrg_state_type state_next;
    logic [24:0] cnt_reg;
    logic [24:0] cnt_next;
    logic [24:0] target_reg;
    logic [24:0] target_next;

    // release sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        target_next = target_reg;
        unique case (state_reg)
            ssrg_pkg::SSRG_HOLD: begin
                cnt_next = '0;
                target_next = delay_target;
                if (!fault) begin
                    state_next = ssrg_pkg::SSRG_COUNT;
                end
            end
            ssrg_pkg::SSRG_COUNT: begin
                if (fault) begin
                    state_next = ssrg_pkg::SSRG_HOLD;
                    cnt_next = '0;
                end else if (cnt_reg == target_reg - 25'h0000001) begin
                    state_next = ssrg_pkg::SSRG_RELEASED;
                end else begin
                    cnt_next = cnt_reg + 25'h0000001;
                end
            end
            ssrg_pkg::SSRG_RELEASED: begin
                if (fault) begin
                    state_next = ssrg_pkg::SSRG_HOLD;
                end
            end
            // spare code of the two-bit encoding falls back to a held reset
            default: state_next = ssrg_pkg::SSRG_HOLD;
        endcase
    end

    // sequencer registers; reset starts held
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= ssrg_pkg::SSRG_HOLD;
            cnt_reg <= '0;
            target_reg <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            target_reg <= target_next;
        end
    end

    // output pin drive per variant, from flops
    logic out_reg;
    logic out_next;
    logic oe_reg;
    logic oe_next;
    logic active_next;
    always_comb begin
        active_next = (state_next != ssrg_pkg::SSRG_RELEASED);
        out_next = ~active_next;
        oe_next = 1'b1;
        unique case (VARIANT)
            ssrg_pkg::VARIANT_PP_HIGH: out_next = active_next;
            ssrg_pkg::VARIANT_OD_LOW: begin
                out_next = 1'b0;
                oe_next = active_next;
            end
            default: out_next = ~active_next;
        endcase
    end

    // pin registers; reset shows the active level of each variant
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            out_reg <= (VARIANT == ssrg_pkg::VARIANT_PP_HIGH);
            oe_reg <= 1'b1;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
        end
    end

    // status flop fed like the pin, so both change on the same edge
    logic active_reg;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            active_reg <= 1'b1;
        end else begin
            active_reg <= active_next;
        end
    end

    // outputs straight from flops, no glitch reaches the pin
    assign reset_out = out_reg;
    assign reset_out_oe = oe_reg;
    assign reset_active = active_reg;

    // assertions
    AST_FAULT_HOLDS: assert property (@(posedge clock) disable iff (rst)
        fault |=> reset_active)
        else $error("reset released while a fault is present");
    AST_SUPPLY_PROP: assert property (@(posedge clock) disable iff (rst)
        $rose(supply_fault) |=> reset_active)
        else $error("supply fault did not assert reset");
    // a pulse shorter than the filter is dropped, so only its end excuses a missing fault
    AST_MANUAL_PROP: assert property (@(posedge clock) disable iff (rst)
        $rose(sync2_reg[1]) |-> ##[0:30] (manual_fault || !sync2_reg[1]))
        else $error("manual reset not seen within delay");
    AST_RELEASE_LATE: assert property (@(posedge clock) disable iff (rst)
        $fell(reset_active) |-> $past(state_reg) == ssrg_pkg::SSRG_COUNT
            && $past(cnt_reg) == $past(target_reg) - 25'h0000001)
        else $error("reset released before full delay");
    AST_ABORT: assert property (@(posedge clock) disable iff (rst)
        (state_reg == ssrg_pkg::SSRG_COUNT && fault) |=> state_reg == ssrg_pkg::SSRG_HOLD)
        else $error("count not abandoned on fault");
    AST_TARGET: assert property (@(posedge clock) disable iff (rst)
        state_reg == ssrg_pkg::SSRG_HOLD |=> target_reg == $past(delay_target))
        else $error("delay target not taken from strap");
    AST_PP_LOW: assert property (@(posedge clock) disable iff (rst)
        VARIANT == ssrg_pkg::VARIANT_PP_LOW |-> reset_out_oe && reset_out == !reset_active)
        else $error("push-pull low output wrong");
    AST_PP_HIGH: assert property (@(posedge clock) disable iff (rst)
        VARIANT == ssrg_pkg::VARIANT_PP_HIGH |-> reset_out_oe && reset_out == reset_active)
        else $error("push-pull high output wrong");
    AST_OD_LOW: assert property (@(posedge clock) disable iff (rst)
        VARIANT == ssrg_pkg::VARIANT_OD_LOW |-> !reset_out && reset_out_oe == reset_active)
        else $error("open-drain output wrong");
    AST_SUPPLY_PERSIST: assert property (@(posedge clock) disable iff (rst)
        $rose(sync2_reg[0]) |-> ##[0:1000] (supply_fault || !sync2_reg[0]))
        else $error("supply fault not seen within delay");
    AST_MANUAL_EARLY: assert property (@(posedge clock) disable iff (rst)
        $rose(manual_fault) |-> $past(sync2_reg[1], 30))
        else $error("manual fault raised before the filter time");
    AST_COUNT_STEP: assert property (@(posedge clock) disable iff (rst)
        (state_reg == ssrg_pkg::SSRG_COUNT && !fault && cnt_reg != target_reg - 25'h0000001)
            |=> state_reg == ssrg_pkg::SSRG_COUNT && cnt_reg == $past(cnt_reg) + 25'h0000001)
        else $error("release count skipped or stalled");
    AST_HOLD_TO_COUNT: assert property (@(posedge clock) disable iff (rst)
        (state_reg == ssrg_pkg::SSRG_HOLD && !fault)
            |=> state_reg == ssrg_pkg::SSRG_COUNT && cnt_reg == 25'h0000000)
        else $error("release count not started from zero");
    AST_RELEASE_CLEAR: assert property (@(posedge clock) disable iff (rst)
        !reset_active |-> !$past(fault))
        else $error("reset released with a fault present");

    // main scenarios: release, abort, reassert, supply fault, long delay
    COV_RELEASE: cover property (@(posedge clock) disable iff (rst) $fell(reset_active));
    COV_ABORT: cover property (@(posedge clock) disable iff (rst)
        state_reg == ssrg_pkg::SSRG_COUNT && fault);
    COV_REASSERT: cover property (@(posedge clock) disable iff (rst) $rose(reset_active));
    COV_SUPPLY_FAULT: cover property (@(posedge clock) disable iff (rst) $rose(supply_fault));
    COV_LONG_DELAY: cover property (@(posedge clock) disable iff (rst)
        state_reg == ssrg_pkg::SSRG_COUNT && target_reg == DELAY_LONG_CYC);
endmodule : ssrg_top

// file: tb/ssrg_cpu_model.sv
// processor side model: sees the reset pin through a pull-up
`timescale 1ns/100ps
module ssrg_cpu_model #(
    parameter bit ACTIVE_HIGH = 1'b0
) (
    // reset pin from the supervisor
    input wire logic reset_out,
    input wire logic reset_out_oe,
    // resolved pin and reset as the processor sees it
    output logic pin_level,
    output logic cpu_held
);
    assign pin_level = reset_out_oe ? reset_out : 1'b1;
    // held while the pin is at its active level
    assign cpu_held = ACTIVE_HIGH ? pin_level : ~pin_level;
endmodule : ssrg_cpu_model

// file: tb/supply_supervisor_reset_gen_bench.sv
// bench for the reset generator: three output variants side by side
`timescale 1ns/100ps
module supply_supervisor_reset_gen_bench;
    // short delays keep the run brief
    localparam int SHORT = 50;
    localparam int LONG = 200;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic supply_low = 1'b0;
    logic manual_reset_n = 1'b1;
    logic delay_select_strap = 1'b0;
    logic [2:0] reset_out;
    logic [2:0] reset_out_oe;
    logic [2:0] reset_active;
    logic [2:0] pin_level;
    logic [2:0] cpu_held;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    // one instance and one processor per variant
    for (genvar g = 0; g < 3; g++) begin : gen_var
        ssrg_top #(.VARIANT(2'(g)), .DELAY_SHORT_CYC(25'h32), .DELAY_LONG_CYC(25'hC8))
        ssrg_top_i (.clock(clock), .rst(rst), .supply_low(supply_low),
            .manual_reset_n(manual_reset_n), .delay_select_strap(delay_select_strap),
            .reset_out(reset_out[g]), .reset_out_oe(reset_out_oe[g]),
            .reset_active(reset_active[g]));
        ssrg_cpu_model #(.ACTIVE_HIGH(g == 1)) ssrg_cpu_model_i (.reset_out(reset_out[g]),
            .reset_out_oe(reset_out_oe[g]), .pin_level(pin_level[g]), .cpu_held(cpu_held[g]));
    end
    // hang guard, the run needs about 1800 cycles
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic seen, input logic exp, input string msg);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    // inputs change 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic check_pins(input logic a);
        for (int g = 0; g < 3; g++) begin
            check(reset_active[g], a, "state");
            check(cpu_held[g], a, "cpu view");
        end
        check(reset_out[0], ~a, "pp low level");
        check(reset_out_oe[0], 1'b1, "pp low drive");
        check(reset_out[1], a, "pp high level");
        check(reset_out_oe[1], 1'b1, "pp high drive");
        check(reset_out[2], 1'b0, "od level");
        check(reset_out_oe[2], a, "od drive");
        check(pin_level[0], ~a, "pp low pin");
        check(pin_level[1], a, "pp high pin");
        check(pin_level[2], ~a, "od pulled pin");
    endtask : check_pins
    // sync and state hops add a few cycles to the delay
    task automatic wait_release(input int d);
        int n;
        n = 0;
        while (reset_active[0] !== 1'b0 && n < d + 12) begin
            step(1);
            n++;
        end
        check(n >= d + 2 && n <= d + 10, 1'b1, "release time");
        check_pins(1'b0);
    endtask : wait_release
    // a fault stays unseen for lo cycles, then shows by hi
    task automatic wait_assert(input int lo, input int hi);
        int n;
        step(lo);
        check(reset_active[0], 1'b0, "early assert");
        n = lo;
        while (reset_active[0] !== 1'b1 && n < hi) begin
            step(1);
            n++;
        end
        check_pins(1'b1);
    endtask : wait_assert
    task automatic test_manual();
        // too short a pulse is filtered out
        manual_reset_n = 1'b0;
        step(10);
        manual_reset_n = 1'b1;
        step(40);
        check(reset_active[0], 1'b0, "short pulse");
        manual_reset_n = 1'b0;
        wait_assert(25, 40);
        manual_reset_n = 1'b1;
        wait_release(SHORT);
        $display("test manual done");
    endtask : test_manual
    task automatic test_supply();
        supply_low = 1'b1;
        wait_assert(990, 1010);
        // manual release cannot end a supply fault
        manual_reset_n = 1'b0;
        step(50);
        manual_reset_n = 1'b1;
        step(100);
        check(reset_active[0], 1'b1, "supply holds");
        supply_low = 1'b0;
        wait_release(SHORT);
        $display("test supply done");
    endtask : test_supply
    task automatic test_long();
        delay_select_strap = 1'b1;
        manual_reset_n = 1'b0;
        wait_assert(25, 40);
        manual_reset_n = 1'b1;
        wait_release(LONG);
        delay_select_strap = 1'b0;
        $display("test long done");
    endtask : test_long
    // a fault in mid-count restarts the full delay
    task automatic test_restart();
        manual_reset_n = 1'b0;
        wait_assert(25, 40);
        manual_reset_n = 1'b1;
        // fault back while counting, well before the release is due
        step(5);
        manual_reset_n = 1'b0;
        for (int i = 0; i < 40; i++) begin
            step(1);
            check(reset_active[0], 1'b1, "held in count");
        end
        manual_reset_n = 1'b1;
        wait_release(SHORT);
        $display("test restart done");
    endtask : test_restart
    // reset held two cycles shows the active level, release then takes the full delay
    task automatic test_reset();
        rst = 1'b1;
        step(2);
        check_pins(1'b1);
        rst = 1'b0;
        wait_release(SHORT);
        $display("test reset done");
    endtask : test_reset
    initial begin
        test_reset();
        test_manual();
        test_supply();
        test_long();
        test_restart();
        // a second reset in mid-run, from the released state
        test_reset();
        print_verdict();
    end
endmodule : supply_supervisor_reset_gen_bench
